// File: verilog/sio_pkg.sv
// constants shared by the special i/o function unit
package sio_pkg;

   // clock and timing
   localparam int CLK_HZ        = 40_000_000;
   localparam int MS_PER_S      = 1000;
   localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int FILTER_POINTS = 8;
   localparam int FILTER_MAX_MS = 15;
   localparam logic [3:0] FILTER_DEF_MS = 4'hA;
   localparam int WIN_STEP_MS   = 10;
   localparam int WIN_MIN       = 1;
   localparam int WIN_MAX       = 100;
   localparam int FREQ_MIN_HZ   = 50;
   localparam int FREQ_MAX_HZ   = 5000;
   localparam int DUTY_MAX      = 100;
   localparam int ANALOG_MAX    = 1000;

   // register byte offsets
   localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
   localparam logic [7:0] OFS_OUT_SEL  = 8'h04;
   localparam logic [7:0] OFS_FILTER   = 8'h08;
   localparam logic [7:0] OFS_CTRL     = 8'h0C;
   localparam logic [7:0] OFS_SET1     = 8'h10;
   localparam logic [7:0] OFS_SET2     = 8'h14;
   localparam logic [7:0] OFS_COUNT1   = 8'h18;
   localparam logic [7:0] OFS_COUNT2   = 8'h1C;
   localparam logic [7:0] OFS_FREQ     = 8'h20;
   localparam logic [7:0] OFS_DUTY     = 8'h24;
   localparam logic [7:0] OFS_ANALOG0  = 8'h28;
   localparam logic [7:0] OFS_ANALOG1  = 8'h2C;
   localparam logic [7:0] OFS_STATUS   = 8'h30;
   localparam logic [7:0] OFS_MASK     = 8'h34;
   localparam logic [7:0] OFS_INPUTS   = 8'h38;
   localparam logic [7:0] OFS_WINDOW   = 8'h3C;

   // function select word fields
   localparam int FS_EN = 0, FS_HSC = 1, FS_I1R = 2, FS_I1F = 3;
   localparam int FS_I2R = 6, FS_I2F = 7, FS_SPD = 10, FS_QUAD = 11;
   localparam int FS_CH1 = 12, FS_FLT = 15;
   // output select word fields
   localparam int OS_EN = 0, OS_PULSE = 1, OS_DIRMODE = 2;
   // control register fields
   localparam int CT_LOCK = 0, CT_GATE = 1, CT_RUN = 3, CT_DIR = 4;
   // status fields: counter match 1/2, interrupt 1/2, window done
   localparam int ST_CH1 = 0, ST_INT1 = 2, ST_SPD = 4, ST_W = 5;

endpackage : sio_pkg

// File: verilog/sio_input_filter.sv
// on/off delay filter shared by a group of inputs
`timescale 1ns/1ps
`default_nettype none
module sio_input_filter
   import sio_pkg::*;
#(
   parameter int N = FILTER_POINTS
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   // timing and setting
   input  wire logic         i_ms_tick,
   input  wire logic [3:0]   i_delay_ms,
   // inputs and filtered levels
   input  wire logic [N-1:0] i_raw,
   output logic      [N-1:0] o_filt
);

   typedef struct packed {
      logic [N-1:0]      filt;
      logic [N-1:0][3:0] cnt;
   } sio_flt_s;

   sio_flt_s q;
   sio_flt_s next_q;

   // a change must persist for the whole delay before it is accepted
   always_comb begin
      next_q = q;
      for (int i = 0; i < N; i++) begin
         if (i_raw[i] == q.filt[i]) begin
            next_q.cnt[i] = 4'h0;
         end else if (i_delay_ms == 4'h0) begin
            next_q.filt[i] = i_raw[i];
         end else if (i_ms_tick) begin
            if (q.cnt[i] + 4'h1 == i_delay_ms) begin
               next_q.filt[i] = i_raw[i];
               next_q.cnt[i]  = 4'h0;
            end else begin
               next_q.cnt[i] = q.cnt[i] + 4'h1;
            end
         end
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_filt = q.filt;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   AST_FILTER_BYPASS: assert property (
      (i_delay_ms == 4'h0 && i_raw != q.filt) |=> q.filt == $past(i_raw))
      else $error("zero delay did not pass input");

endmodule // sio_input_filter
`default_nettype wire

// File: verilog/sio_pulse_out.sv
// variable frequency pulse and pwm generator for the field outputs
`timescale 1ns/1ps
`default_nettype none
module sio_pulse_out
   import sio_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // settings
   input  wire logic        i_enable,
   input  wire logic        i_pwm,
   input  wire logic        i_dir_method,
   input  wire logic        i_dir,
   input  wire logic [12:0] i_freq,
   input  wire logic [6:0]  i_duty,
   // field outputs
   output logic             o_out0,
   output logic             o_out1
);

   typedef struct packed {
      logic [25:0] acc;
      logic        level;
      logic [6:0]  step;
      logic        out0;
      logic        out1;
   } sio_pls_s;

   sio_pls_s q;
   sio_pls_s next_q;

   // phase accumulator: wraps at the clock rate, exact mean frequency
   always_comb begin
      logic [26:0] inc;
      logic [26:0] sum;
      inc = i_pwm ? 27'(i_freq * DUTY_MAX) : 27'({i_freq, 1'b0});
      sum = 27'(q.acc) + inc;
      next_q = q;
      if (!i_enable) begin
         next_q = '0;
      end else if (sum >= 27'(CLK_HZ)) begin
         next_q.acc   = 26'(sum - 27'(CLK_HZ));
         next_q.level = ~q.level;
         next_q.step  = (q.step == 7'(DUTY_MAX - 1)) ? 7'h00 : q.step + 7'h01;
      end else begin
         next_q.acc = 26'(sum);
      end
      if (!i_enable) begin
         next_q.out0 = 1'b0;
         next_q.out1 = 1'b0;
      end else if (i_pwm) begin
         next_q.out0 = next_q.step < i_duty;
         next_q.out1 = 1'b0;
      end else if (i_dir_method) begin
         next_q.out0 = next_q.level;
         next_q.out1 = i_dir;
      end else begin
         next_q.out0 = next_q.level & ~i_dir;
         next_q.out1 = next_q.level & i_dir;
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_out0 = q.out0;
   assign o_out1 = q.out1;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   AST_PWM_ZERO: assert property (
      (i_enable && i_pwm && i_duty == 7'h00)[*2] |=> !o_out0)
      else $error("pwm output high at zero duty");

   AST_PWM_FULL: assert property (
      (i_enable && i_pwm && i_duty == 7'(DUTY_MAX))[*2] |=> o_out0)
      else $error("pwm output low at full duty");

endmodule // sio_pulse_out
`default_nettype wire

// File: verilog/sio_special_io.sv
// special i/o function unit: filter, counters, interrupts, analog, outputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - input filter delay settable 0 to 15 ms in 1 ms steps, default 10
// - one filter setting applies to the first eight inputs as a group
// - up-counter on two channels, count inputs 0 and 1, resets 2 and 3
// - speed-counter counts pulses per window of 10 to 1000 ms, inputs 0 and 1
// - quadrature: A on input 0, B on 1, reset on 2; A leading counts up
// - selected edge on input 2 or 3 raises interrupt program 3 or 4
// - two adjusters converted to values 0 to 1000 and stored, always on
// - pulse output 50 to 5000 Hz in 1 Hz steps on output 0, or on output 1 when reversed in cw/ccw mode
// - pwm output on output 0 with duty 0 to 100 percent in 1 percent steps
// - counter, interrupt and output functions only on dc input variants
// - select words are taken only before the scan lock, then ignored
module sio_special_io
   import sio_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
   parameter bit          DC_INPUT  = 1'b1
)
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // field side
   input  wire logic [7:0]  i_field_input,
   input  wire logic [9:0]  i_adjuster_0,
   input  wire logic [9:0]  i_adjuster_1,
   output logic             o_field_output_0,
   output logic             o_field_output_1,
   // interrupt
   output logic             o_irq
);

   typedef struct packed {
      logic [15:0]         ms_cnt;
      logic                ms_tick;
      logic [7:0]          sync1;
      logic [7:0]          sync2;
      logic [7:0]          prev;
      logic [1:0][9:0]     adj1;
      logic [1:0][9:0]     adj2;
      logic [1:0][9:0]     adj3;
      logic [1:0][9:0]     analog;
      logic [15:0]         fsel;
      logic [15:0]         osel;
      logic                locked;
      logic [3:0]          flt;
      logic [1:0]          gate;
      logic                run;
      logic                dir;
      logic [1:0][15:0]    setv;
      logic [1:0][15:0]    cnt;
      logic [1:0][15:0]    acc;
      logic [6:0]          win;
      logic [9:0]          win_ms;
      logic [12:0]         freq;
      logic [6:0]          duty;
      logic [ST_W-1:0]     st;
      logic [ST_W-1:0]     mask;
      logic                irq;
      logic [15:0]         rdata;
   } sio_top_s;

   sio_top_s    q;
   sio_top_s    next_q;
   logic [7:0]  rise;
   logic [7:0]  fall;
   logic [7:0]  filt;
   logic        fn_en;
   logic        mode_up;
   logic        mode_spd;
   logic        mode_quad;
   logic        mode_int;
   logic        win_end;
   logic        out_en;
   logic [3:0]  delay_ms;

   // limit a setting to its documented range
   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input int lo,
                                         input int hi);
      if (v < 16'(lo)) begin
         return 16'(lo);
      end else if (v > 16'(hi)) begin
         return 16'(hi);
      end
      return v;
   endfunction

   // edges of synchronised pins, counters bypass the slow filter
   assign rise = q.sync2 & ~q.prev;
   assign fall = ~q.sync2 & q.prev;

   // mode decode: counter modes and interrupt inputs exclude each other
   assign fn_en     = DC_INPUT && q.fsel[FS_EN];
   assign mode_quad = fn_en && q.fsel[FS_HSC] && q.fsel[FS_QUAD];
   assign mode_spd  = fn_en && q.fsel[FS_HSC] && !q.fsel[FS_QUAD]
                      && q.fsel[FS_SPD];
   assign mode_up   = fn_en && q.fsel[FS_HSC] && !q.fsel[FS_QUAD]
                      && !q.fsel[FS_SPD];
   assign mode_int  = fn_en && !q.fsel[FS_HSC];
   assign win_end   = mode_spd && q.ms_tick
                      && q.win_ms == 10'(q.win * WIN_STEP_MS - 1);
   assign out_en    = DC_INPUT && q.osel[OS_EN] && q.run;

   // filter setting is used only when selected, otherwise default delay
   assign delay_ms = q.fsel[FS_FLT] ? q.flt : FILTER_DEF_MS;

   // one shared delay for the whole group of eight inputs
   sio_input_filter #(
      .N          (FILTER_POINTS)
   ) u_filter (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_ms_tick  (q.ms_tick),
      .i_delay_ms (delay_ms),
      .i_raw      (q.sync2),
      .o_filt     (filt)
   );

   // pulse train or pwm on the field outputs, never both
   sio_pulse_out u_pulse (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .i_enable     (out_en),
      .i_pwm        (!q.osel[OS_PULSE]),
      .i_dir_method (q.osel[OS_DIRMODE]),
      .i_dir        (q.dir),
      .i_freq       (q.freq),
      .i_duty       (q.duty),
      .o_out0       (o_field_output_0),
      .o_out1       (o_field_output_1)
   );

   // next state of the whole unit
   always_comb begin
      logic [ST_W-1:0] ev;
      logic [ST_W-1:0] clr;
      ev = '0;
      clr = '0;
      next_q = q;

      // millisecond time base
      next_q.ms_tick = 1'b0;
      if (q.ms_cnt == 16'(MS_CYCLES - 1)) begin
         next_q.ms_cnt  = 16'h0000;
         next_q.ms_tick = 1'b1;
      end else begin
         next_q.ms_cnt = q.ms_cnt + 16'h0001;
      end

      // pin synchronisers
      next_q.sync1 = i_field_input;
      next_q.sync2 = q.sync1;
      next_q.prev  = q.sync2;
      next_q.adj1  = {i_adjuster_1, i_adjuster_0};
      next_q.adj2  = q.adj1;
      next_q.adj3  = q.adj2;

      // analog values, taken once settled, no selection needed
      for (int c = 0; c < 2; c++) begin
         if (q.ms_tick && q.adj2[c] == q.adj3[c]) begin
            next_q.analog[c] = 10'(clamp(16'(q.adj2[c]), 0,
                                         ANALOG_MAX));
         end
      end

      // up-counter and speed-counter channels
      for (int c = 0; c < 2; c++) begin
         if (mode_up && q.fsel[FS_CH1 + c]) begin
            if (!q.gate[c] || q.sync2[c + 2]) begin
               next_q.cnt[c] = 16'h0000;
            end else if (rise[c]) begin
               if (q.cnt[c] + 16'h0001 == q.setv[c]) begin
                  next_q.cnt[c]     = 16'h0000;
                  ev[ST_CH1 + c]    = 1'b1;
               end else begin
                  next_q.cnt[c] = q.cnt[c] + 16'h0001;
               end
            end
         end
         if (mode_spd && q.fsel[FS_CH1 + c]) begin
            if (win_end) begin
               next_q.cnt[c] = q.acc[c];
               next_q.acc[c] = 16'(rise[c]);
            end else if (rise[c] && q.acc[c] != 16'hFFFF) begin
               next_q.acc[c] = q.acc[c] + 16'h0001;
            end
         end
      end

      // sampling window in milliseconds, restarted when its length is written
      if (!mode_spd || (i_wr && i_addr == OFS_WINDOW)) begin
         next_q.win_ms = 10'h000;
      end else if (q.ms_tick) begin
         next_q.win_ms = win_end ? 10'h000 : q.win_ms + 10'h001;
      end
      if (win_end) begin
         ev[ST_SPD] = 1'b1;
      end

      // quadrature counter on channel 1
      if (mode_quad) begin
         if (q.sync2[2]) begin
            next_q.cnt[0] = 16'h0000;
         end else if (rise[0] && !q.sync2[1]) begin
            next_q.cnt[0] = q.cnt[0] + 16'h0001;
         end else if (rise[0] && q.sync2[1]) begin
            next_q.cnt[0] = q.cnt[0] - 16'h0001;
         end
      end

      // edge interrupt inputs
      if (mode_int) begin
         ev[ST_INT1]     = (q.fsel[FS_I1R] & rise[2])
                           | (q.fsel[FS_I1F] & fall[2]);
         ev[ST_INT1 + 1] = (q.fsel[FS_I2R] & rise[3])
                           | (q.fsel[FS_I2F] & fall[3]);
      end

      // register writes
      if (i_wr) begin
         case (i_addr)
            OFS_FUNC_SEL: if (!q.locked) next_q.fsel = i_wdata;
            OFS_OUT_SEL:  if (!q.locked) next_q.osel = i_wdata;
            OFS_FILTER:   next_q.flt = 4'(clamp(i_wdata, 0,
                                                FILTER_MAX_MS));
            OFS_CTRL: begin
               next_q.locked = q.locked | i_wdata[CT_LOCK];
               next_q.gate   = i_wdata[CT_GATE +: 2];
               next_q.run    = i_wdata[CT_RUN];
               next_q.dir    = i_wdata[CT_DIR];
            end
            OFS_SET1:     next_q.setv[0] = i_wdata;
            OFS_SET2:     next_q.setv[1] = i_wdata;
            OFS_FREQ:     next_q.freq = 13'(clamp(i_wdata, FREQ_MIN_HZ,
                                                  FREQ_MAX_HZ));
            OFS_DUTY:     next_q.duty = 7'(clamp(i_wdata, 0,
                                                 DUTY_MAX));
            OFS_WINDOW:   next_q.win = 7'(clamp(i_wdata, WIN_MIN,
                                                WIN_MAX));
            OFS_STATUS:   clr = i_wdata[ST_W-1:0];
            OFS_MASK:     next_q.mask = i_wdata[ST_W-1:0];
            default: ;
         endcase
      end

      // sticky status, a new event beats a clear in the same cycle
      next_q.st  = (q.st & ~clr) | ev;
      next_q.irq = |(next_q.st & next_q.mask);

      // read data stand for the one cycle after the strobe
      next_q.rdata = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            OFS_FUNC_SEL: next_q.rdata = q.fsel;
            OFS_OUT_SEL:  next_q.rdata = q.osel;
            OFS_FILTER:   next_q.rdata = 16'(q.flt);
            OFS_CTRL:     next_q.rdata = 16'({q.dir, q.run, q.gate,
                                              q.locked});
            OFS_SET1:     next_q.rdata = q.setv[0];
            OFS_SET2:     next_q.rdata = q.setv[1];
            OFS_COUNT1:   next_q.rdata = q.cnt[0];
            OFS_COUNT2:   next_q.rdata = q.cnt[1];
            OFS_FREQ:     next_q.rdata = 16'(q.freq);
            OFS_DUTY:     next_q.rdata = 16'(q.duty);
            OFS_ANALOG0:  next_q.rdata = 16'(q.analog[0]);
            OFS_ANALOG1:  next_q.rdata = 16'(q.analog[1]);
            OFS_STATUS:   next_q.rdata = 16'(q.st);
            OFS_MASK:     next_q.rdata = 16'(q.mask);
            OFS_INPUTS:   next_q.rdata = 16'(filt);
            OFS_WINDOW:   next_q.rdata = 16'(q.win);
            default:      next_q.rdata = 16'h0000;
         endcase
      end
   end

   // state register with documented defaults
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q         <= '0;
         q.flt     <= FILTER_DEF_MS;
         q.win     <= 7'(WIN_MIN);
         q.freq    <= 13'(FREQ_MIN_HZ);
         q.setv    <= {16'hFFFF, 16'hFFFF};
      end else begin
         q <= next_q;
      end
   end

   assign o_rdata = q.rdata;
   assign o_irq   = q.irq;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // rising edge seen on interrupt pin 1 while that edge is selected
   sequence s_int1_rise;
      (mode_int && q.fsel[FS_I1R] && !q.sync2[2]) ##1 q.sync2[2];
   endsequence

   AST_LOCK_HOLDS: assert property (
      (q.locked && i_wr && i_addr == OFS_FUNC_SEL)
      |=> q.fsel == $past(q.fsel))
      else $error("select word changed after lock");

   AST_MODE_ONE: assert property (
      $onehot0({mode_up, mode_spd, mode_quad, mode_int}))
      else $error("more than one counter or interrupt mode");

   AST_UP_WRAP: assert property (
      (mode_up && q.fsel[FS_CH1] && q.gate[0] && !q.sync2[2] && rise[0]
       && q.cnt[0] + 16'h0001 == q.setv[0])
      |=> q.cnt[0] == 16'h0000 && q.st[ST_CH1])
      else $error("up-counter did not wrap at set value");

   AST_QUAD_UP: assert property (
      (mode_quad && rise[0] && !q.sync2[1] && !q.sync2[2])
      |=> q.cnt[0] == $past(q.cnt[0]) + 16'h0001)
      else $error("quadrature did not count up with a leading");

   AST_QUAD_DOWN: assert property (
      (mode_quad && rise[0] && q.sync2[1] && !q.sync2[2])
      |=> q.cnt[0] == $past(q.cnt[0]) - 16'h0001)
      else $error("quadrature did not count down with b leading");

   AST_INT1_EDGE: assert property (
      s_int1_rise |=> q.st[ST_INT1] && (o_irq || !q.mask[ST_INT1]))
      else $error("interrupt 1 edge not flagged");

   AST_SPEED_WIN: assert property (
      mode_spd |-> q.win_ms < 10'(q.win * WIN_STEP_MS)
      && q.win >= 7'(WIN_MIN) && q.win <= 7'(WIN_MAX))
      else $error("sampling window out of range");

   AST_ANALOG_MAX: assert property (
      q.analog[0] <= 10'(ANALOG_MAX) && q.analog[1] <= 10'(ANALOG_MAX))
      else $error("analog value above limit");

   AST_FREQ_RANGE: assert property (
      q.freq >= 13'(FREQ_MIN_HZ) && q.freq <= 13'(FREQ_MAX_HZ))
      else $error("pulse frequency out of range");

   AST_DUTY_RANGE: assert property (
      q.duty <= 7'(DUTY_MAX))
      else $error("pwm duty out of range");

   AST_DC_ONLY: assert property (
      !DC_INPUT |-> !fn_en && !out_en && !o_field_output_0)
      else $error("dc-only function active on other variant");

   AST_FILTER_GROUP: assert property (
      !q.fsel[FS_FLT] |-> delay_ms == FILTER_DEF_MS)
      else $error("filter default not applied");

endmodule // sio_special_io
`default_nettype wire

// File: tb/sio_field_src.sv
// field pulse source model driving one counter input pin
`timescale 1ns/1ps
`default_nettype none
module sio_field_src (
   // clock, reset and command
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_go,
   input  wire logic [7:0] i_count,
   // field pin and activity
   output logic            o_pin,
   output logic            o_busy
);
   logic [7:0] left;
   logic [2:0] ph;
   // each pulse is 4 clocks low then 4 clocks high, well over the minimum
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         left <= 8'h00;
         ph   <= 3'h0;
      end else if (i_go) begin
         left <= i_count;
         ph   <= 3'h0;
      end else if (left != 8'h00) begin
         ph <= ph + 3'h1;
         if (ph == 3'h7) left <= left - 8'h01;
      end
   end
   assign o_pin  = (left != 8'h00) && ph[2];
   assign o_busy = (left != 8'h00);
endmodule // sio_field_src
`default_nettype wire

// File: tb/special_io_function_unit_test.sv
// self-checking bench for the special i/o function unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module special_io_function_unit_test;
   import sio_pkg::*;
   logic        clk, resetn, wr, rd, go, out0, out1, irq, busy, pin;
   logic [7:0]  addr, bench_in, cnt;
   logic [15:0] wdata, rdata;
   logic [9:0]  adj0, adj1;
   int          miscompares, n_tests, cyc, r, h, r1;
   // dut, field source on input 0, bench on the other inputs
   sio_special_io #(.MS_CYCLES(40), .DC_INPUT(1'b1)) u_dut (
      .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_field_input({bench_in[7:1], pin}), .i_adjuster_0(adj0),
      .i_adjuster_1(adj1), .o_field_output_0(out0),
      .o_field_output_1(out1), .o_irq(irq));
   sio_field_src u_src (.i_clk(clk), .i_resetn(resetn), .i_go(go),
      .i_count(cnt), .o_pin(pin), .o_busy(busy));
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task rst;
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
   endtask
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK($sformatf("reg %h", a), e, rdata)
      @(posedge clk);
   endtask
   task pulses(input logic [7:0] n);
      @(posedge clk);
      go <= 1'b1; cnt <= n;
      @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < 3000 && (k < 2 || busy); k++) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask
   // counts rises and high cycles of output 0 and rises of output 1
   task watch(input int n);
      logic p, p1;
      p = out0;
      p1 = out1;
      r = 0;
      h = 0;
      r1 = 0;
      repeat (n) begin
         @(posedge clk);
         #1 r += int'(out0 && !p);
         h += int'(out0);
         r1 += int'(out1 && !p1);
         p = out0;
         p1 = out1;
      end
   endtask
   // main sequence
   initial begin
      {wr, rd, go, addr, wdata, cnt, bench_in} = '0;
      resetn = 1'b0; adj0 = 10'h3FF; adj1 = 10'h1F4;
      rst;
      rd_chk(OFS_FILTER, 16'h000A);
      rd_chk(OFS_FREQ, 16'h0032);
      rd_chk(8'h40, 16'h0000);
      bench_in[5] <= 1'b1;
      repeat (320) @(posedge clk);
      rd_chk(OFS_INPUTS, 16'h0000);
      repeat (160) @(posedge clk);
      rd_chk(OFS_INPUTS, 16'h0020);
      rd_chk(OFS_ANALOG0, 16'h03E8);
      rd_chk(OFS_ANALOG1, 16'h01F4);
      wr_reg(OFS_FILTER, 16'h0020);
      rd_chk(OFS_FILTER, 16'h000F);
      wr_reg(OFS_FILTER, 16'h0000);
      wr_reg(OFS_FUNC_SEL, 16'h8000);
      bench_in[6] <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk(OFS_INPUTS, 16'h0060);
      $display("test filter and analog done");
      // up-counter, match, reset pin, lock
      rst; bench_in <= 8'h00;
      wr_reg(OFS_FUNC_SEL, 16'h1003);
      wr_reg(OFS_SET1, 16'h0005);
      wr_reg(OFS_CTRL, 16'h0003);
      wr_reg(OFS_FUNC_SEL, 16'h0005);
      rd_chk(OFS_FUNC_SEL, 16'h1003);
      pulses(8'h03);
      rd_chk(OFS_COUNT1, 16'h0003);
      pulses(8'h02);
      rd_chk(OFS_COUNT1, 16'h0000);
      pulses(8'h02);
      bench_in[2] <= 1'b1;
      repeat (8) @(posedge clk);
      rd_chk(OFS_COUNT1, 16'h0000);
      rd_chk(OFS_STATUS, 16'h0001);
      $display("test up counter done");
      // quadrature direction
      rst; bench_in <= 8'h00;
      wr_reg(OFS_FUNC_SEL, 16'h1803);
      wr_reg(OFS_CTRL, 16'h0003);
      pulses(8'h04);
      bench_in[1] <= 1'b1;
      pulses(8'h01);
      rd_chk(OFS_COUNT1, 16'h0003);
      $display("test quadrature done");
      // speed counter over one 10 ms window
      rst; bench_in <= 8'h00;
      rd_chk(OFS_WINDOW, 16'h0001);
      wr_reg(OFS_FUNC_SEL, 16'h1403);
      pulses(8'h05);
      repeat (400) @(posedge clk);
      rd_chk(OFS_COUNT1, 16'h0005);
      rd_chk(OFS_STATUS, 16'h0010);
      $display("test speed counter done");
      // interrupt inputs, edge select, mask and clear
      rst; bench_in <= 8'h00;
      wr_reg(OFS_FUNC_SEL, 16'h3085);
      wr_reg(OFS_MASK, 16'h0004);
      wr_reg(OFS_CTRL, 16'h0001);
      bench_in[3] <= 1'b1;
      repeat (8) @(posedge clk);
      rd_chk(OFS_STATUS, 16'h0000);
      bench_in[2] <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      bench_in[3] <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk(OFS_STATUS, 16'h000C);
      wr_reg(OFS_STATUS, 16'h0004);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      wr_reg(OFS_MASK, 16'h000C);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      $display("test interrupts done");
      // pwm duty ends, then pulse frequency
      rst;
      wr_reg(OFS_OUT_SEL, 16'h0001);
      wr_reg(OFS_FREQ, 16'h1388);
      wr_reg(OFS_CTRL, 16'h0008);
      repeat (9000) @(posedge clk);
      watch(400);
      `CHK("pwm high", 0, h)
      wr_reg(OFS_DUTY, 16'h0064);
      repeat (9000) @(posedge clk);
      watch(400);
      `CHK("pwm high", 400, h)
      wr_reg(OFS_OUT_SEL, 16'h0003);
      repeat (100) @(posedge clk);
      watch(40000);
      `CHK("pulse rises", 1'b1, (r >= 4 && r <= 5))
      wr_reg(OFS_CTRL, 16'h0018);
      repeat (100) @(posedge clk);
      watch(8000);
      `CHK("cw line high", 0, h)
      `CHK("ccw rises", 1, r1)
      wr_reg(OFS_OUT_SEL, 16'h0007);
      repeat (100) @(posedge clk);
      watch(8000);
      `CHK("pulse line rises", 1, r)
      `CHK("dir level", 1'b1, out1)
      $display("test outputs done");
      tally_and_finish;
   end
endmodule // special_io_function_unit_test
`default_nettype wire
